// ### rtl/srm_pkg.sv
// Purpose: shared types, decode tables and timing constants for the redriver mux control
// Assumes: 25 MHz REF_CLK; analog path and comparators live outside this logic
// Notes:   times are kept in their own unit and converted to cycles here
package srm_pkg;

  typedef enum logic [1:0] {
    LVL_LOW   = 2'h0,
    LVL_FLOAT = 2'h1,
    LVL_HIGH  = 2'h2
  } srm_level_t;

  typedef enum logic [1:0] {
    DE_0DB   = 2'h0,
    DE_3P5DB = 2'h1,
    DE_6DB   = 2'h2
  } srm_deemph_t;

  typedef enum logic {
    SW_0V9 = 1'h0,
    SW_1V1 = 1'h1
  } srm_swing_t;

  typedef enum logic [1:0] {
    EQ_0DB = 2'h0,
    EQ_3DB = 2'h1,
    EQ_6DB = 2'h2,
    EQ_9DB = 2'h3
  } srm_eq_t;

  typedef struct packed {
    srm_deemph_t deemph;
    srm_swing_t  swing;
    srm_eq_t     equalize;
  } srm_chan_cfg_t;

  typedef enum logic [2:0] {
    ST_RAMP      = 3'h0,
    ST_DISC      = 3'h1,
    ST_DISC_WAKE = 3'h2,
    ST_U0        = 3'h3,
    ST_U2U3      = 3'h4,
    ST_U23_CHK   = 3'h5,
    ST_U23_WAKE  = 3'h6
  } srm_state_t;

  localparam int CLK_PERIOD_PS   = 40000;
  localparam int IDLE_ENTRY_NS   = 6;
  localparam int U1_EXIT_NS      = 6;
  localparam int U23_EXIT_NS     = 1000;
  localparam int DISC_EXIT_NS    = 2000;
  localparam int PWRUP_ACTIVE_MS = 30;
  localparam int RXDET_PERIOD_US = 100;
  localparam int U2_ENTRY_US     = 300;

  // least times round up, never below one cycle
  localparam int IDLE_ENTRY_RAW = (IDLE_ENTRY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IDLE_ENTRY_CYC = (IDLE_ENTRY_RAW < 1) ? 1 : IDLE_ENTRY_RAW;
  localparam int U1_EXIT_RAW    = (U1_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int U1_EXIT_CYC    = (U1_EXIT_RAW < 1) ? 1 : U1_EXIT_RAW;
  localparam int U23_EXIT_CYC   = (U23_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DISC_EXIT_CYC  = (DISC_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PWRUP_ACTIVE_CYC = PWRUP_ACTIVE_MS * (1000000000 / CLK_PERIOD_PS);
  localparam logic [11:0] RXDET_PERIOD_CYC = 12'(RXDET_PERIOD_US * 1000000 / CLK_PERIOD_PS);
  localparam int U2_ENTRY_CYC_DFLT = U2_ENTRY_US * 1000000 / CLK_PERIOD_PS;

  localparam logic [15:0] DISC_WAKE_LOAD = 16'(DISC_EXIT_CYC - 2);
  localparam logic [15:0] U23_WAKE_LOAD  = 16'(U23_EXIT_CYC - 2);

  function automatic srm_chan_cfg_t srm_ch1_decode(input srm_level_t a, input srm_level_t b);
    srm_chan_cfg_t c;
    c = '{DE_3P5DB, SW_1V1, EQ_3DB};
    unique case ({a, b})
      {LVL_LOW, LVL_LOW}:     c = '{DE_3P5DB, SW_1V1, EQ_3DB};
      {LVL_LOW, LVL_FLOAT}:   c = '{DE_3P5DB, SW_0V9, EQ_3DB};
      {LVL_LOW, LVL_HIGH}:    c = '{DE_0DB,   SW_1V1, EQ_3DB};
      {LVL_FLOAT, LVL_LOW}:   c = '{DE_0DB,   SW_0V9, EQ_3DB};
      {LVL_FLOAT, LVL_FLOAT}: c = '{DE_3P5DB, SW_1V1, EQ_0DB};
      {LVL_FLOAT, LVL_HIGH}:  c = '{DE_3P5DB, SW_0V9, EQ_0DB};
      {LVL_HIGH, LVL_LOW}:    c = '{DE_0DB,   SW_1V1, EQ_0DB};
      {LVL_HIGH, LVL_FLOAT}:  c = '{DE_0DB,   SW_0V9, EQ_0DB};
      {LVL_HIGH, LVL_HIGH}:   c = '{DE_6DB,   SW_1V1, EQ_6DB};
      default:                c = '{DE_3P5DB, SW_1V1, EQ_0DB};
    endcase
    return c;
  endfunction

  function automatic srm_chan_cfg_t srm_ch2_decode(input srm_level_t a, input srm_level_t b);
    srm_chan_cfg_t c;
    c = '{DE_6DB, SW_1V1, EQ_0DB};
    unique case ({a, b})
      {LVL_LOW, LVL_LOW}:     c = '{DE_6DB,   SW_1V1, EQ_0DB};
      {LVL_LOW, LVL_FLOAT}:   c = '{DE_3P5DB, SW_1V1, EQ_0DB};
      {LVL_LOW, LVL_HIGH}:    c = '{DE_3P5DB, SW_0V9, EQ_0DB};
      {LVL_FLOAT, LVL_LOW}:   c = '{DE_6DB,   SW_0V9, EQ_0DB};
      {LVL_FLOAT, LVL_FLOAT}: c = '{DE_3P5DB, SW_1V1, EQ_6DB};
      {LVL_FLOAT, LVL_HIGH}:  c = '{DE_3P5DB, SW_0V9, EQ_6DB};
      {LVL_HIGH, LVL_LOW}:    c = '{DE_6DB,   SW_1V1, EQ_6DB};
      {LVL_HIGH, LVL_FLOAT}:  c = '{DE_6DB,   SW_0V9, EQ_6DB};
      {LVL_HIGH, LVL_HIGH}:   c = '{DE_6DB,   SW_1V1, EQ_9DB};
      default:                c = '{DE_3P5DB, SW_1V1, EQ_6DB};
    endcase
    return c;
  endfunction

endpackage

// ### rtl/srm_tri_level.sv
// Purpose: resolve one tri-level strap from its two threshold comparators
// Assumes: above_hi means pin above the high threshold, below_lo below the low one
// Notes:   both comparators set at once is impossible on a sane pin and reads as float
`timescale 1ns/1ps
`default_nettype none
module srm_tri_level
  import srm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic above_hi,
  input  wire logic below_lo,
  output var  srm_level_t level
);

  srm_level_t level_reg;
  srm_level_t level_next;

  always_comb begin
    level_next = LVL_FLOAT;
    if (above_hi && !below_lo) begin
      level_next = LVL_HIGH;
    end else if (below_lo && !above_hi) begin
      level_next = LVL_LOW;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= LVL_FLOAT;
    end else begin
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule
`default_nettype wire

// ### rtl/srm_top.sv
// Purpose: control logic of a two-channel 5 Gbps redriver with 2:1 orientation mux
// Assumes: receiver detect, idle and LFPS sensing are done by analog blocks reporting here
// Notes:   all timing in REF_CLK cycles; outputs are registered
`timescale 1ns/1ps
`default_nettype none
module srm_top
  import srm_pkg::*;
#(
  parameter int U2_ENTRY_CYC = U2_ENTRY_CYC_DFLT
) (
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  input  wire logic       SUPPLY_GOOD,
  input  wire logic       ORIENT_SEL,
  input  wire logic       CH1_CFG_IN_A_HI,
  input  wire logic       CH1_CFG_IN_A_LO,
  input  wire logic       CH1_CFG_IN_B_HI,
  input  wire logic       CH1_CFG_IN_B_LO,
  input  wire logic       CH2_CFG_IN_A_HI,
  input  wire logic       CH2_CFG_IN_A_LO,
  input  wire logic       CH2_CFG_IN_B_HI,
  input  wire logic       CH2_CFG_IN_B_LO,
  input  wire logic       TERM_VALID,
  input  wire logic       TERM_SEEN_1,
  input  wire logic       TERM_SEEN_2,
  input  wire logic       IN_IDLE,
  input  wire logic       IN_LFPS,
  output logic            RXDET_REQ,
  output logic            RX_TERM_EN,
  output logic            MUX_POS1_EN,
  output logic            MUX_POS2_EN,
  output logic            OUT_IDLE,
  output logic            LFPS_TX_EN,
  output logic            LINK_ACTIVE,
  output logic [2:0]      POWER_STATE,
  output logic [1:0]      PROC_SIDE_DEEMPH,
  output logic            PROC_SIDE_SWING,
  output logic [1:0]      PROC_SIDE_EQUALIZE,
  output logic [1:0]      CONN_SIDE_DEEMPH,
  output logic            CONN_SIDE_SWING,
  output logic [1:0]      CONN_SIDE_EQUALIZE
);

  localparam logic [15:0] U2_ENTRY_LAST = 16'(U2_ENTRY_CYC - 1);

  srm_level_t    lvl [4];
  srm_chan_cfg_t cfg1;
  srm_chan_cfg_t cfg2;
  srm_state_t    state_reg;
  srm_state_t    state_next;
  logic [15:0]   tmr_reg;
  logic [15:0]   tmr_next;
  logic [11:0]   rxdet_cnt_reg;
  logic [11:0]   rxdet_cnt_next;
  logic          rxdet_req_next;
  logic          lfps_wake;
  logic          both_ok;
  logic          term_en_next;
  logic          lfps_next;
  logic          out_idle_next;
  srm_chan_cfg_t cfg1_next;
  srm_chan_cfg_t cfg2_next;
  srm_chan_cfg_t cfg1_reg;
  srm_chan_cfg_t cfg2_reg;

  logic [3:0] str_hi;
  logic [3:0] str_lo;
  assign str_hi = {CH2_CFG_IN_B_HI, CH2_CFG_IN_A_HI, CH1_CFG_IN_B_HI, CH1_CFG_IN_A_HI};
  assign str_lo = {CH2_CFG_IN_B_LO, CH2_CFG_IN_A_LO, CH1_CFG_IN_B_LO, CH1_CFG_IN_A_LO};

  // order: ch1 a, ch1 b, ch2 a, ch2 b
  for (genvar i = 0; i < 4; i++) begin : g_strap
    srm_tri_level u_tri (
      .clk      (REF_CLK),
      .rst      (RST),
      .above_hi (str_hi[i]),
      .below_lo (str_lo[i]),
      .level    (lvl[i])
    );
  end

  assign cfg1 = srm_ch1_decode(lvl[0], lvl[1]);
  assign cfg2 = srm_ch2_decode(lvl[2], lvl[3]);

  // power state group
  always_comb begin
    state_next     = state_reg;
    tmr_next       = tmr_reg;
    rxdet_cnt_next = rxdet_cnt_reg;
    rxdet_req_next = 1'b0;
    lfps_wake      = 1'b0;
    both_ok        = TERM_VALID && TERM_SEEN_1 && TERM_SEEN_2;
    if (!SUPPLY_GOOD) begin
      state_next     = ST_RAMP;
      tmr_next       = 16'h0000;
      rxdet_cnt_next = 12'h000;
    end else begin
      unique case (state_reg)
        ST_RAMP: begin
          // first detect goes out at once so active is reached well inside the power-up bound
          state_next     = ST_DISC;
          rxdet_cnt_next = 12'h000;
        end
        ST_DISC: begin
          if (rxdet_cnt_reg == 12'h000) begin
            rxdet_req_next = 1'b1;
            rxdet_cnt_next = RXDET_PERIOD_CYC - 12'h001;
          end else begin
            rxdet_cnt_next = rxdet_cnt_reg - 12'h001;
          end
          if (both_ok) begin
            state_next = ST_DISC_WAKE;
            tmr_next   = DISC_WAKE_LOAD;
          end
        end
        ST_DISC_WAKE, ST_U23_WAKE: begin
          if (tmr_reg == 16'h0000) begin
            state_next = ST_U0;
            lfps_wake  = 1'b1;
          end else begin
            tmr_next = tmr_reg - 16'h0001;
          end
        end
        ST_U0: begin
          // traffic or LFPS keeps the link up; only sustained idle drops it
          if (!IN_IDLE || IN_LFPS) begin
            tmr_next = 16'h0000;
          end else if (tmr_reg == U2_ENTRY_LAST) begin
            state_next     = ST_U2U3;
            tmr_next       = 16'h0000;
            rxdet_cnt_next = RXDET_PERIOD_CYC - 12'h001;
          end else begin
            tmr_next = tmr_reg + 16'h0001;
          end
        end
        ST_U2U3: begin
          if (!IN_IDLE) begin
            state_next     = ST_U23_CHK;
            rxdet_req_next = 1'b1;
          end else if (TERM_VALID && !both_ok) begin
            state_next     = ST_DISC;
            rxdet_cnt_next = 12'h000;
          end else if (rxdet_cnt_reg == 12'h000) begin
            rxdet_req_next = 1'b1;
            rxdet_cnt_next = RXDET_PERIOD_CYC - 12'h001;
          end else begin
            rxdet_cnt_next = rxdet_cnt_reg - 12'h001;
          end
        end
        ST_U23_CHK: begin
          if (both_ok) begin
            state_next = ST_U23_WAKE;
            tmr_next   = U23_WAKE_LOAD;
          end else if (TERM_VALID) begin
            state_next     = ST_DISC;
            rxdet_cnt_next = 12'h000;
          end
        end
        default: begin
          state_next = ST_RAMP;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_reg     <= ST_RAMP;
      tmr_reg       <= 16'h0000;
      rxdet_cnt_reg <= 12'h000;
    end else begin
      state_reg     <= state_next;
      tmr_reg       <= tmr_next;
      rxdet_cnt_reg <= rxdet_cnt_next;
    end
  end

  // output group
  always_comb begin
    term_en_next = (state_next != ST_RAMP) && (state_next != ST_DISC);
    if (state_reg == ST_U0 && state_next == ST_U0) begin
      lfps_next     = IN_LFPS;
      out_idle_next = IN_IDLE && !IN_LFPS;
    end else begin
      lfps_next     = lfps_wake;
      out_idle_next = !lfps_wake;
    end
    cfg1_next = cfg1;
    cfg2_next = cfg2;
    if (lfps_next) begin
      cfg1_next.deemph = DE_0DB;
      cfg2_next.deemph = DE_0DB;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RXDET_REQ   <= 1'b0;
      RX_TERM_EN  <= 1'b0;
      MUX_POS1_EN <= 1'b0;
      MUX_POS2_EN <= 1'b0;
      OUT_IDLE    <= 1'b1;
      LFPS_TX_EN  <= 1'b0;
      LINK_ACTIVE <= 1'b0;
      POWER_STATE <= ST_RAMP;
      cfg1_reg    <= '{DE_0DB, SW_0V9, EQ_0DB};
      cfg2_reg    <= '{DE_0DB, SW_0V9, EQ_0DB};
    end else begin
      RXDET_REQ   <= rxdet_req_next;
      RX_TERM_EN  <= term_en_next;
      MUX_POS1_EN <= ORIENT_SEL;
      MUX_POS2_EN <= !ORIENT_SEL;
      OUT_IDLE    <= out_idle_next;
      LFPS_TX_EN  <= lfps_next;
      LINK_ACTIVE <= (state_next == ST_U0);
      POWER_STATE <= state_next;
      cfg1_reg    <= cfg1_next;
      cfg2_reg    <= cfg2_next;
    end
  end

  assign PROC_SIDE_DEEMPH   = cfg1_reg.deemph;
  assign PROC_SIDE_SWING    = cfg1_reg.swing;
  assign PROC_SIDE_EQUALIZE = cfg1_reg.equalize;
  assign CONN_SIDE_DEEMPH   = cfg2_reg.deemph;
  assign CONN_SIDE_SWING    = cfg2_reg.swing;
  assign CONN_SIDE_EQUALIZE = cfg2_reg.equalize;

  a_mux_pos_one: assert property (@(posedge REF_CLK) disable iff (RST)
    ORIENT_SEL |=> (MUX_POS1_EN && !MUX_POS2_EN)) else $error("position 1 not routed");
  a_mux_pos_two: assert property (@(posedge REF_CLK) disable iff (RST)
    !ORIENT_SEL |=> (!MUX_POS1_EN && MUX_POS2_EN)) else $error("position 2 not routed");
  a_term_off_disc: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_reg == ST_DISC || state_reg == ST_RAMP) |-> !RX_TERM_EN) else $error("termination on while undetected");
  a_ramp_hold_off: assert property (@(posedge REF_CLK) disable iff (RST)
    !SUPPLY_GOOD |=> (state_reg == ST_RAMP && !RX_TERM_EN)) else $error("not held during ramp");
  a_disc_needs_both: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_reg == ST_DISC && SUPPLY_GOOD && !both_ok) |=> (state_reg == ST_DISC)) else $error("left disconnect early");
  a_disc_wake_time: assert property (@(posedge REF_CLK) disable iff (RST || !SUPPLY_GOOD)
    (state_reg == ST_DISC && both_ok) |-> ##50 (LFPS_TX_EN && state_reg == ST_U0))
    else $error("disconnect exit timing");
  a_u23_wake_time: assert property (@(posedge REF_CLK) disable iff (RST || !SUPPLY_GOOD)
    (state_reg == ST_U23_CHK && both_ok) |-> ##25 (LFPS_TX_EN && state_reg == ST_U0)) else $error("u2u3 exit timing");
  a_u0_keeps_traffic: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_reg == ST_U0 && !IN_IDLE && SUPPLY_GOOD) |=> (state_reg == ST_U0)) else $error("left U0 with traffic");
  a_idle_entry_delay: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_reg == ST_U0 && IN_IDLE && !IN_LFPS && SUPPLY_GOOD && tmr_reg != U2_ENTRY_LAST) |=> OUT_IDLE)
    else $error("idle entry late");
  a_lfps_u1_exit: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_reg == ST_U0 && IN_LFPS && SUPPLY_GOOD) |=> (LFPS_TX_EN && !OUT_IDLE)) else $error("lfps not forwarded");
  a_lfps_deemph_off: assert property (@(posedge REF_CLK) disable iff (RST)
    LFPS_TX_EN |-> (PROC_SIDE_DEEMPH == DE_0DB && CONN_SIDE_DEEMPH == DE_0DB)) else $error("deemphasis during lfps");
  a_rxdet_poll: assert property (@(posedge REF_CLK) disable iff (RST)
    (SUPPLY_GOOD && IN_IDLE && !TERM_VALID && state_reg == ST_U2U3 && rxdet_cnt_reg == 12'h000) |=> RXDET_REQ)
    else $error("missed periodic detect");
  a_ch2_max_eq: assert property (@(posedge REF_CLK) disable iff (RST)
    (lvl[2] == LVL_HIGH && lvl[3] == LVL_HIGH && !lfps_next) |=>
    (CONN_SIDE_EQUALIZE == EQ_9DB && CONN_SIDE_DEEMPH == DE_6DB))
    else $error("ch2 decode wrong");
  a_ch1_fh_decode: assert property (@(posedge REF_CLK) disable iff (RST)
    (lvl[0] == LVL_FLOAT && lvl[1] == LVL_HIGH && !lfps_next) |=>
    (PROC_SIDE_DEEMPH == DE_3P5DB && PROC_SIDE_SWING == SW_0V9 && PROC_SIDE_EQUALIZE == EQ_0DB))
    else $error("ch1 decode wrong");

endmodule
`default_nettype wire

// ### bench/srm_far_end.sv
// Purpose: far-end receiver model that answers receiver-detect requests
// Assumes: one answer per request, DLY cycles after the request pulse
// Notes:   result lines carry no meaning outside the valid pulse
`timescale 1ns/1ps
`default_nettype none
module srm_far_end #(
  parameter int DLY = 3
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic rxdet_req,
  input  wire logic present_1,
  input  wire logic present_2,
  output logic      term_valid,
  output logic      term_seen_1,
  output logic      term_seen_2
);
  int cnt;

  always @(posedge clk) begin
    if (rst) begin
      cnt         <= 0;
      term_valid  <= 1'b0;
      term_seen_1 <= 1'b0;
      term_seen_2 <= 1'b0;
    end else begin
      // a new request restarts the countdown
      if (rxdet_req) begin
        cnt <= DLY;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
      if (cnt == 1) begin
        term_valid  <= 1'b1;
        term_seen_1 <= present_1;  // both outputs reported in one result
        term_seen_2 <= present_2;
      end else begin
        // no pull on these lines: toggle so a stale result never looks valid
        term_valid  <= 1'b0;
        term_seen_1 <= ~term_seen_1;
        term_seen_2 <= ~term_seen_2;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/ss_redriver_mux_config_test.sv
// Purpose: self-checking bench for the redriver mux control
// Assumes: idle-to-U2/U3 count shortened to 20 cycles
// Notes:   inputs change at rising edges, outputs sampled at falling edges
`timescale 1ns/1ps
`default_nettype none
module ss_redriver_mux_config_test
  import srm_pkg::*;
;
  // {deemph, swing, equalize} per strap pair, index a*3+b with low/float/high = 0/1/2
  localparam logic [4:0] CH1_TBL [9] = '{5'h0D, 5'h09, 5'h05, 5'h01, 5'h0C, 5'h08, 5'h04, 5'h00, 5'h16};
  localparam logic [4:0] CH2_TBL [9] = '{5'h14, 5'h0C, 5'h08, 5'h10, 5'h0E, 5'h0A, 5'h16, 5'h12, 5'h17};

  logic        clk, rst, supply_good, orient_sel, in_idle, in_lfps, present_1, present_2;
  logic [3:0]  cfg_hi, cfg_lo;
  logic        term_valid, term_seen_1, term_seen_2, rxdet_req, rx_term_en, mux_pos1_en, mux_pos2_en;
  logic        out_idle, lfps_tx_en, link_active, proc_side_swing, conn_side_swing;
  logic [2:0]  power_state;
  logic [1:0]  proc_side_deemph, proc_side_equalize, conn_side_deemph, conn_side_equalize;
  logic [31:0] rng;
  int          miscompares, samples_checked, lv[4], t0, i, p;
  int          cyc = 0;

  srm_top #(.U2_ENTRY_CYC(20)) dut (
    .REF_CLK(clk), .RST(rst), .SUPPLY_GOOD(supply_good), .ORIENT_SEL(orient_sel),
    .CH1_CFG_IN_A_HI(cfg_hi[0]), .CH1_CFG_IN_A_LO(cfg_lo[0]), .CH1_CFG_IN_B_HI(cfg_hi[1]),
    .CH1_CFG_IN_B_LO(cfg_lo[1]), .CH2_CFG_IN_A_HI(cfg_hi[2]), .CH2_CFG_IN_A_LO(cfg_lo[2]),
    .CH2_CFG_IN_B_HI(cfg_hi[3]), .CH2_CFG_IN_B_LO(cfg_lo[3]), .TERM_VALID(term_valid),
    .TERM_SEEN_1(term_seen_1), .TERM_SEEN_2(term_seen_2), .IN_IDLE(in_idle), .IN_LFPS(in_lfps),
    .RXDET_REQ(rxdet_req), .RX_TERM_EN(rx_term_en), .MUX_POS1_EN(mux_pos1_en), .MUX_POS2_EN(mux_pos2_en),
    .OUT_IDLE(out_idle), .LFPS_TX_EN(lfps_tx_en), .LINK_ACTIVE(link_active), .POWER_STATE(power_state),
    .PROC_SIDE_DEEMPH(proc_side_deemph), .PROC_SIDE_SWING(proc_side_swing),
    .PROC_SIDE_EQUALIZE(proc_side_equalize), .CONN_SIDE_DEEMPH(conn_side_deemph),
    .CONN_SIDE_SWING(conn_side_swing), .CONN_SIDE_EQUALIZE(conn_side_equalize)
  );

  srm_far_end #(.DLY(3)) far (
    .clk(clk), .rst(rst), .rxdet_req(rxdet_req), .present_1(present_1), .present_2(present_2),
    .term_valid(term_valid), .term_seen_1(term_seen_1), .term_seen_2(term_seen_2)
  );

  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wait_state(input logic [2:0] st, input int lim);
    int n;
    n = 0;
    while (power_state !== st && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (power_state !== st) begin
      miscompares++;
      $display("unexpected at %0t: state %h never reached %h", $time, power_state, st);
      finish_test();
    end
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    while (term_valid !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (term_valid !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: no detect result", $time);
      finish_test();
    end
  endtask

  // counts cycles from the detect result to the link turning active
  task automatic time_wake(input int exp);
    int n;
    wait_valid();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (link_active !== 1'b1 && n < 100);
    check(8'(n), 8'(exp));
    check({6'h00, lfps_tx_en, rx_term_en}, 8'h03);
  endtask

  task automatic check_straps(input logic lfps_on);
    check({lfps_on ? 3'h0 : 3'h0, lfps_on ? 2'h0 : proc_side_deemph, proc_side_swing, proc_side_equalize},
          {3'h0, CH1_TBL[lv[0] * 3 + lv[1]] & (lfps_on ? 5'h07 : 5'h1F)});
    check({3'h0, conn_side_deemph, conn_side_swing, conn_side_equalize},
          {3'h0, CH2_TBL[lv[2] * 3 + lv[3]] & (lfps_on ? 5'h07 : 5'h1F)});
    if (lfps_on) begin
      check({4'h0, proc_side_deemph, conn_side_deemph}, 8'h00);
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    $display("unexpected at %0t: run too long", $time);
    finish_test();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    supply_good = 1'b0;
    orient_sel = 1'b0;
    in_idle = 1'b0;
    in_lfps = 1'b0;
    cfg_hi = 4'h0;
    cfg_lo = 4'h0;
    present_1 = 1'b1;
    present_2 = 1'b0;
    rng = 32'h9A4B;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({power_state, rx_term_en, mux_pos1_en, mux_pos2_en, out_idle, 1'b0}, 8'h02);
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      for (p = 0; p < 4; p++) begin
        rng = xs(rng);
        lv[p] = rng[1:0] % 3;
        // float shown either as neither or as both comparators set
        cfg_hi[p] <= (lv[p] == 2) || (lv[p] == 1 && rng[2]);
        cfg_lo[p] <= (lv[p] == 0) || (lv[p] == 1 && rng[2]);
      end
      orient_sel <= rng[3];
      @(posedge clk);
      @(negedge clk);
      check({6'h00, mux_pos1_en, mux_pos2_en}, {6'h00, rng[3], !rng[3]});
      @(negedge clk);
      check_straps(1'b0);
    end
    @(posedge clk);
    supply_good <= 1'b1;
    t0 = cyc;
    wait_state(3'h1, 5);
    // first detect request follows entry into disconnect at once, as a one-cycle pulse
    @(negedge clk);
    check({7'h00, rxdet_req}, 8'h01);
    @(negedge clk);
    check({7'h00, rxdet_req}, 8'h00);
    // first answer reports only one port: must stay disconnected, unterminated
    wait_valid();
    repeat (3) @(negedge clk);
    check({4'h0, power_state, rx_term_en}, 8'h02);
    @(posedge clk);
    present_2 <= 1'b1;
    time_wake(50);
    check({7'h00, (cyc - t0) < PWRUP_ACTIVE_CYC}, 8'h01);
    @(posedge clk);
    in_lfps <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check({6'h00, lfps_tx_en, out_idle}, 8'h02);
    check_straps(1'b1);
    @(posedge clk);
    in_lfps <= 1'b0;
    in_idle <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check({6'h00, lfps_tx_en, out_idle}, 8'h01);
    check_straps(1'b0);
    repeat (14) @(posedge clk);
    in_idle <= 1'b0;
    @(posedge clk);
    in_idle <= 1'b1;
    repeat (15) @(negedge clk);
    check({5'h00, power_state}, 8'h03);
    wait_state(3'h4, 30);
    check({5'h00, link_active, lfps_tx_en, out_idle}, 8'h01);
    @(posedge clk);
    in_idle <= 1'b0;
    time_wake(25);
    @(posedge clk);
    in_idle <= 1'b1;
    wait_state(3'h4, 40);
    @(posedge clk);
    present_1 <= 1'b0;
    present_2 <= 1'b0;
    wait_state(3'h1, 3000);
    check({7'h00, rx_term_en}, 8'h00);
    @(posedge clk);
    supply_good <= 1'b0;
    wait_state(3'h0, 3);
    check({6'h00, rx_term_en, link_active}, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
